//--- shared/qbsi_pkg.sv
// package for the processor-bus slave image translation block
package qbsi_pkg;

    // register offsets
    localparam logic [11:0] OFF_IMG0_CTL = 12'hf00;
    localparam logic [11:0] OFF_IMG0_XLAT = 12'hf04;
    localparam logic [11:0] OFF_IMG1_CTL = 12'hf10;
    localparam logic [11:0] OFF_IMG1_XLAT = 12'hf14;

    // control register fields
    localparam int POS_POST = 31;
    localparam int POS_IO = 24;
    localparam int POS_PREF = 23;

    // translation register fields
    localparam int POS_TA_LO = 16;
    localparam int POS_SIZE_LO = 4;
    localparam int POS_XEN = 0;

    localparam logic [31:0] CTL_MASK = 32'h8180_0000;
    localparam logic [31:0] XLAT_MASK = 32'hffff_00f1;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // pipeline latency from request to answer, in cycles
    localparam int ANSWER_LAT = 1;

    typedef enum {
        CYC_DELAYED_READ,
        CYC_PREFETCH_READ,
        CYC_DELAYED_WRITE,
        CYC_POSTED_WRITE,
        CYC_BUS_ERROR
    } cycle_kind_t;

    typedef struct packed {
        logic post_allow;
        logic io_space;
        logic prefetch_allow;
    } image_ctl_t;

    typedef struct packed {
        logic [15:0] translation_address;
        logic [3:0] window_size_code;
        logic enable;
    } image_xlat_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic burst;
        logic image_choice;
    } access_req_t;

endpackage

//--- core/qbsi_image_xlat.sv
// slave image select, cycle decode and address translation
`timescale 1ns/1ns

// Operation
// - translated range of the PCI address comes from the translation address field
// - translation is applied only while the image translation enable is set
// - size code n translates lines 31 down to 16 plus n
// - chip select with image choice 1 uses image 1 settings
// - chip select with image choice 0 uses image 0 settings
// - io space bit picks I/O space when 1, memory when 0
// - single read prefetches only with prefetch allowed in memory space
// - burst read is delayed in memory space, bus error in I/O space
// - single write posts only with posting allowed in memory space
// - burst write posts in memory space, bus error in I/O space
// - image 1 registers reset to zero on general reset, no EEPROM load
// - image 0 translation resets on PCI reset and can load from EEPROM
// - image 0 posting and space bits load from EEPROM, prefetch does not
module qbsi_image_xlat (
    // clock, resets, enable
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic pci_resetn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic reg_sel_i,
    input wire logic reg_wr_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    // serial EEPROM load for image 0
    input wire logic ee_load_i,
    input wire logic [31:0] ee_ctl_i,
    input wire logic [31:0] ee_xlat_i,
    // processor-bus access
    input wire logic bridge_chip_select_i,
    input wire qbsi_pkg::access_req_t req_i,
    // answers
    output logic [31:0] reg_rdata_o,
    output logic pci_valid_o,
    output logic [31:0] pci_addr_o,
    output logic pci_io_space_o,
    output qbsi_pkg::cycle_kind_t cycle_kind_o,
    output logic bus_error_o
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] img0_ctl_r, img0_ctl_nxt;
    logic [31:0] img0_xlat_r, img0_xlat_nxt;
    logic [31:0] img1_ctl_r, img1_ctl_nxt;
    logic [31:0] img1_xlat_r, img1_xlat_nxt;
    logic [31:0] reg_rdata_r, reg_rdata_nxt;

    always_comb begin
        img0_ctl_nxt = img0_ctl_r;
        img0_xlat_nxt = img0_xlat_r;
        img1_ctl_nxt = img1_ctl_r;
        img1_xlat_nxt = img1_xlat_r;
        reg_rdata_nxt = 32'h0000_0000;
        if (ee_load_i) begin
            // prefetch allow keeps its value, only post and space load
            img0_ctl_nxt = (ee_ctl_i & qbsi_pkg::CTL_MASK & ~(32'h1 << qbsi_pkg::POS_PREF))
                | (img0_ctl_r & (32'h1 << qbsi_pkg::POS_PREF));
            img0_xlat_nxt = ee_xlat_i & qbsi_pkg::XLAT_MASK;
        end else if (reg_sel_i && reg_wr_i) begin
            case (reg_addr_i)
                qbsi_pkg::OFF_IMG0_CTL: img0_ctl_nxt = reg_wdata_i & qbsi_pkg::CTL_MASK;
                qbsi_pkg::OFF_IMG0_XLAT: img0_xlat_nxt = reg_wdata_i & qbsi_pkg::XLAT_MASK;
                qbsi_pkg::OFF_IMG1_CTL: img1_ctl_nxt = reg_wdata_i & qbsi_pkg::CTL_MASK;
                qbsi_pkg::OFF_IMG1_XLAT: img1_xlat_nxt = reg_wdata_i & qbsi_pkg::XLAT_MASK;
                default: ;
            endcase
        end
        if (reg_sel_i && !reg_wr_i) begin
            case (reg_addr_i)
                qbsi_pkg::OFF_IMG0_CTL: reg_rdata_nxt = img0_ctl_r;
                qbsi_pkg::OFF_IMG0_XLAT: reg_rdata_nxt = img0_xlat_r;
                qbsi_pkg::OFF_IMG1_CTL: reg_rdata_nxt = img1_ctl_r;
                qbsi_pkg::OFF_IMG1_XLAT: reg_rdata_nxt = img1_xlat_r;
                default: reg_rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // image 0 lives in the PCI reset domain
    always_ff @(posedge mclk_i or negedge pci_resetn_i) begin
        if (!pci_resetn_i) begin
            img0_ctl_r <= qbsi_pkg::REG_RESET;
            img0_xlat_r <= qbsi_pkg::REG_RESET;
        end else if (clk_en_i) begin
            img0_ctl_r <= img0_ctl_nxt;
            img0_xlat_r <= img0_xlat_nxt;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            img1_ctl_r <= qbsi_pkg::REG_RESET;
            img1_xlat_r <= qbsi_pkg::REG_RESET;
            reg_rdata_r <= 32'h0000_0000;
        end else if (clk_en_i) begin
            img1_ctl_r <= img1_ctl_nxt;
            img1_xlat_r <= img1_xlat_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    assign reg_rdata_o = reg_rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // access decode and translation
    qbsi_pkg::image_ctl_t ctl_sel;
    qbsi_pkg::image_xlat_t xl_sel;
    logic [31:0] xmask;
    logic [31:0] addr_nxt;
    qbsi_pkg::cycle_kind_t kind_nxt;

    logic pci_valid_r, pci_valid_nxt;
    logic [31:0] pci_addr_r;
    logic pci_io_r;
    qbsi_pkg::cycle_kind_t kind_r;
    logic berr_r, berr_nxt;

    always_comb begin
        if (req_i.image_choice) begin
            ctl_sel = {img1_ctl_r[qbsi_pkg::POS_POST], img1_ctl_r[qbsi_pkg::POS_IO],
                img1_ctl_r[qbsi_pkg::POS_PREF]};
            xl_sel = {img1_xlat_r[31:16], img1_xlat_r[7:4], img1_xlat_r[qbsi_pkg::POS_XEN]};
        end else begin
            ctl_sel = {img0_ctl_r[qbsi_pkg::POS_POST], img0_ctl_r[qbsi_pkg::POS_IO],
                img0_ctl_r[qbsi_pkg::POS_PREF]};
            xl_sel = {img0_xlat_r[31:16], img0_xlat_r[7:4], img0_xlat_r[qbsi_pkg::POS_XEN]};
        end
    end

    // one mask bit per address line translated
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_mask
            if (gi < qbsi_pkg::POS_TA_LO) begin : g_lo
                assign xmask[gi] = 1'b0;
            end else begin : g_hi
                assign xmask[gi] = xl_sel.enable
                    && ((gi - qbsi_pkg::POS_TA_LO) >= int'(xl_sel.window_size_code));
            end
        end
    endgenerate

    always_comb begin
        addr_nxt = (req_i.addr & ~xmask)
            | ({xl_sel.translation_address, 16'h0000} & xmask);
        pci_valid_nxt = bridge_chip_select_i;
        berr_nxt = 1'b0;
        case ({req_i.write, req_i.burst})
            2'b00: kind_nxt = (ctl_sel.prefetch_allow && !ctl_sel.io_space)
                ? qbsi_pkg::CYC_PREFETCH_READ : qbsi_pkg::CYC_DELAYED_READ;
            2'b01: kind_nxt = ctl_sel.io_space ? qbsi_pkg::CYC_BUS_ERROR : qbsi_pkg::CYC_DELAYED_READ;
            2'b10: kind_nxt = (ctl_sel.post_allow && !ctl_sel.io_space)
                ? qbsi_pkg::CYC_POSTED_WRITE : qbsi_pkg::CYC_DELAYED_WRITE;
            2'b11: kind_nxt = ctl_sel.io_space ? qbsi_pkg::CYC_BUS_ERROR : qbsi_pkg::CYC_POSTED_WRITE;
            default: kind_nxt = qbsi_pkg::CYC_DELAYED_READ;
        endcase
        if (bridge_chip_select_i && kind_nxt == qbsi_pkg::CYC_BUS_ERROR) begin
            berr_nxt = 1'b1;
            pci_valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pci_valid_r <= 1'b0;
            pci_addr_r <= 32'h0000_0000;
            pci_io_r <= 1'b0;
            kind_r <= qbsi_pkg::CYC_DELAYED_READ;
            berr_r <= 1'b0;
        end else if (clk_en_i) begin
            pci_valid_r <= pci_valid_nxt;
            pci_addr_r <= addr_nxt;
            pci_io_r <= ctl_sel.io_space;
            kind_r <= kind_nxt;
            berr_r <= berr_nxt;
        end
    end

    assign pci_valid_o = pci_valid_r;
    assign pci_addr_o = pci_addr_r;
    assign pci_io_space_o = pci_io_r;
    assign cycle_kind_o = kind_r;
    assign bus_error_o = berr_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_img1_reset_zero: assert property (@(posedge mclk_i) !resetn_i |-> ##1 (img1_ctl_r == 32'h0 || !resetn_i))
        else $error("image 1 control not zero under reset");
    chk_burst_io_error: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && bridge_chip_select_i && req_i.burst && ctl_sel.io_space) |=> (bus_error_o && !pci_valid_o))
        else $error("burst to io space without bus error");
    chk_burst_wr_post: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && bridge_chip_select_i && req_i.burst && req_i.write && !ctl_sel.io_space)
        |=> (pci_valid_o && cycle_kind_o == qbsi_pkg::CYC_POSTED_WRITE))
        else $error("memory burst write not posted");
    chk_single_wr_post: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && !req_i.burst && req_i.write) |=> ((cycle_kind_o == qbsi_pkg::CYC_POSTED_WRITE)
        == ($past(ctl_sel.post_allow) && !$past(ctl_sel.io_space))))
        else $error("single write posting wrong");
    chk_single_rd_pref: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && !req_i.burst && !req_i.write) |=> ((cycle_kind_o == qbsi_pkg::CYC_PREFETCH_READ)
        == ($past(ctl_sel.prefetch_allow) && !$past(ctl_sel.io_space))))
        else $error("single read prefetch wrong");
    chk_no_xlat_pass: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && !xl_sel.enable) |=> (pci_addr_o == $past(req_i.addr)))
        else $error("address changed with translation off");
    chk_low_lines_pass: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        clk_en_i |=> (pci_addr_o[15:0] == $past(req_i.addr[15:0])))
        else $error("low address lines altered");
    chk_top_line_xlat: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && xl_sel.enable) |=> (pci_addr_o[31] == $past(xl_sel.translation_address[15])))
        else $error("line 31 not translated");
    chk_size_boundary: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && xl_sel.enable && xl_sel.window_size_code == 4'hf)
        |=> (pci_addr_o[30:0] == $past(req_i.addr[30:0])))
        else $error("size code 15 translated more than line 31");
    chk_io_space_out: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (clk_en_i && req_i.image_choice) |=> (pci_io_space_o == $past(img1_ctl_r[qbsi_pkg::POS_IO])))
        else $error("image 1 space bit not used");

    cov_posted: cover property (@(posedge mclk_i) pci_valid_o && cycle_kind_o == qbsi_pkg::CYC_POSTED_WRITE);
    cov_berr: cover property (@(posedge mclk_i) bus_error_o);
    cov_prefetch: cover property (@(posedge mclk_i) pci_valid_o && cycle_kind_o == qbsi_pkg::CYC_PREFETCH_READ);
    cov_ee_load: cover property (@(posedge mclk_i) ee_load_i && clk_en_i);

endmodule

//--- verif/cpu_bus_model.sv
// processor-bus master model issuing slave image accesses
`timescale 1ns/1ns
module cpu_bus_model (
    // clock
    input wire logic mclk_i,
    // access request
    output logic cs_o,
    output qbsi_pkg::access_req_t req_o
);
    initial begin
        cs_o = 1'b0;
        req_o = '0;
    end
    ////////////////////////////////////////////////////////////
    task automatic issue(input logic img, input logic wr, input logic bst, input logic [31:0] a);
        @(negedge mclk_i);
        cs_o = 1'b1;
        req_o = {a, wr, bst, img};
        @(negedge mclk_i);
        cs_o = 1'b0;
        // released lines never keep the last value
        req_o = ~req_o;
    endtask
endmodule

//--- verif/qbus_slave_image_translation_tb_top.sv
// self-checking bench for the slave image translation block
`timescale 1ns/1ns
module qbus_slave_image_translation_tb_top;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic pci_resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic reg_sel_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic ee_load_i = 1'b0;
    logic [31:0] ee_ctl_i = 32'h0;
    logic [31:0] ee_xlat_i = 32'h0;
    logic cs;
    qbsi_pkg::access_req_t req;
    logic [31:0] rdata;
    logic [31:0] paddr;
    logic pvalid;
    logic pio;
    logic berr;
    qbsi_pkg::cycle_kind_t kind;
    int bad_count = 0;
    int checks_done = 0;
    logic [31:0] ctl [2] = '{32'h0, 32'h0};
    logic [31:0] xl [2] = '{32'h0, 32'h0};
    always #5 mclk_i = ~mclk_i;
    qbsi_image_xlat DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .pci_resetn_i(pci_resetn_i),
        .clk_en_i(clk_en_i), .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .ee_load_i(ee_load_i), .ee_ctl_i(ee_ctl_i), .ee_xlat_i(ee_xlat_i),
        .bridge_chip_select_i(cs), .req_i(req), .reg_rdata_o(rdata), .pci_valid_o(pvalid),
        .pci_addr_o(paddr), .pci_io_space_o(pio), .cycle_kind_o(kind), .bus_error_o(berr));
    cpu_bus_model bm (.mclk_i(mclk_i), .cs_o(cs), .req_o(req));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_addr(logic [31:0] x, logic [31:0] a);
        logic [31:0] r;
        r = a;
        for (int i = 16; i < 32; i++)
            if (x[0] && (i - 16) >= x[7:4]) r[i] = x[i];
        return r;
    endfunction
    function automatic qbsi_pkg::cycle_kind_t exp_kind(logic [31:0] c, logic w, logic b);
        if (b && c[24]) return qbsi_pkg::CYC_BUS_ERROR;
        if (b) return w ? qbsi_pkg::CYC_POSTED_WRITE : qbsi_pkg::CYC_DELAYED_READ;
        if (w) return (c[31] && !c[24]) ? qbsi_pkg::CYC_POSTED_WRITE : qbsi_pkg::CYC_DELAYED_WRITE;
        return (c[23] && !c[24]) ? qbsi_pkg::CYC_PREFETCH_READ : qbsi_pkg::CYC_DELAYED_READ;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge mclk_i);
        {reg_sel_i, reg_wr_i, reg_addr_i, reg_wdata_i} = {2'b11, a, d};
        @(negedge mclk_i);
        reg_sel_i = 1'b0;
    endtask
    task automatic reg_chk(input logic [11:0] a, input logic [31:0] e);
        @(negedge mclk_i);
        {reg_sel_i, reg_wr_i, reg_addr_i} = {2'b10, a};
        @(negedge mclk_i);
        reg_sel_i = 1'b0;
        cmp(rdata, e);
    endtask
    task automatic set_img(input logic i, input logic [31:0] c, input logic [31:0] x);
        logic [11:0] b;
        b = i ? qbsi_pkg::OFF_IMG1_CTL : qbsi_pkg::OFF_IMG0_CTL;
        ctl[i] = c & qbsi_pkg::CTL_MASK;
        xl[i] = x & qbsi_pkg::XLAT_MASK;
        reg_wr(b, c);
        reg_wr(b + 12'h4, x);
        reg_chk(b, ctl[i]);
        reg_chk(b + 12'h4, xl[i]);
    endtask
    task automatic acc(input logic i, input logic w, input logic b, input logic [31:0] a);
        qbsi_pkg::cycle_kind_t k;
        logic e;
        k = exp_kind(ctl[i], w, b);
        e = (k == qbsi_pkg::CYC_BUS_ERROR);
        bm.issue(i, w, b, a);
        cmp(32'(kind), 32'(k));
        cmp({31'h0, berr}, {31'h0, e});
        cmp({31'h0, pvalid}, {31'h0, !e});
        if (!e) begin
            cmp(paddr, exp_addr(xl[i], a));
            cmp({31'h0, pio}, {31'h0, ctl[i][24]});
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        // about thirteen times the expected run of some 1500 cycles
        #200_000;
        bad_count++;
        test_done();
    end
    initial begin
        void'($urandom(48300));
        repeat (8) @(negedge mclk_i);
        resetn_i = 1'b1;
        pci_resetn_i = 1'b1;
        for (int j = 0; j < 4; j++) reg_chk(12'(32'hf00 + 16 * j[1] + 4 * j[0]), 32'h0);
        reg_wr(12'hf08, 32'hffff_ffff);
        reg_chk(12'hf08, 32'h0);
        // every control code and every size code, all four access kinds
        for (int j = 0; j < 16; j++) begin
            set_img(j[0], {j[1], 6'h0, j[2], j[3], 23'h0}, {16'ha5c3, 8'h0, 4'(j), 4'h1});
            for (int k = 0; k < 4; k++) acc(j[0], k[0], k[1], $urandom);
        end
        repeat (100) begin
            set_img(1'($urandom), $urandom, $urandom);
            repeat (2) acc(1'($urandom), 1'($urandom), 1'($urandom), $urandom);
        end
        // eeprom load keeps the prefetch bit
        set_img(1'b0, 32'h0080_0000, 32'h0);
        {ee_ctl_i, ee_xlat_i} = {32'h8100_0000, $urandom};
        ee_load_i = 1'b1;
        @(negedge mclk_i);
        ee_load_i = 1'b0;
        reg_chk(qbsi_pkg::OFF_IMG0_CTL, 32'h8180_0000);
        reg_chk(qbsi_pkg::OFF_IMG0_XLAT, ee_xlat_i & qbsi_pkg::XLAT_MASK);
        pci_resetn_i = 1'b0;
        @(negedge mclk_i);
        pci_resetn_i = 1'b1;
        reg_chk(qbsi_pkg::OFF_IMG0_CTL, 32'h0);
        reg_chk(qbsi_pkg::OFF_IMG0_XLAT, 32'h0);
        reg_chk(qbsi_pkg::OFF_IMG1_XLAT, xl[1]);
        // image 0 must survive the general reset
        reg_wr(qbsi_pkg::OFF_IMG0_XLAT, 32'h5a3c_0071);
        resetn_i = 1'b0;
        @(negedge mclk_i);
        resetn_i = 1'b1;
        reg_chk(qbsi_pkg::OFF_IMG1_CTL, 32'h0);
        reg_chk(qbsi_pkg::OFF_IMG1_XLAT, 32'h0);
        reg_chk(qbsi_pkg::OFF_IMG0_XLAT, 32'h5a3c_0071);
        test_done();
    end
endmodule
